// File: rtl/iaus_pkg.sv
// iaus_pkg: constants and types of the programming sequencer.
// assumes one clock domain; all byte fields are 8 bits wide.
package iaus_pkg;
  localparam logic [7:0]  CMD_PROGRAM    = 8'h14;
  localparam logic [1:0]  MODE_AUTH      = 2'h0;
  localparam logic [1:0]  MODE_PROG      = 2'h1;
  localparam logic [1:0]  MODE_VERIFY    = 2'h2;
  localparam logic [7:0]  AUTH_OK        = 8'h00;
  localparam logic [7:0]  AUTH_CORRUPT   = 8'h01;
  localparam logic [7:0]  AUTH_LOWVER    = 8'h05;
  localparam logic [7:0]  AUTH_BADID     = 8'h0a;
  localparam logic [7:0]  AUTH_OUTDATED  = 8'h0b;
  localparam logic [7:0]  AUTH_NOVERIFY  = 8'h0c;
  localparam logic [7:0]  STAT_OK        = 8'h00;
  localparam logic [7:0]  STAT_AUTH      = 8'h01;
  localparam logic [7:0]  STAT_PROG      = 8'h02;
  localparam logic [7:0]  FLASH_READ     = 8'h03;
  localparam logic [23:0] DIR_UPD_OFF    = 24'h000006;
  localparam logic [31:0] BLANK_ADDR     = 32'hffffffff;
  localparam logic [15:0] LAST_ADDR      = 16'h0003;
  localparam logic [15:0] LAST_DIR       = 16'h0005;
  localparam logic [15:0] HDR_ID         = 16'h0000;
  localparam logic [15:0] HDR_VLO        = 16'h0001;
  localparam logic [15:0] HDR_VHI        = 16'h0002;
  localparam logic [15:0] HDR_FLG        = 16'h0003;
  localparam logic [15:0] HDR_LLO        = 16'h0004;
  localparam logic [15:0] HDR_LHI        = 16'h0005;
  localparam int          FLG_VERIFY_OK  = 0;
  localparam int          FLG_OUTDATED   = 1;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h00,
    ST_OPT  = 5'h01,
    ST_ADR  = 5'h03,
    ST_BHD  = 5'h02,
    ST_PAY  = 5'h06,
    ST_WRT  = 5'h07,
    ST_GAP  = 5'h05,
    ST_CHK  = 5'h04,
    ST_RSP  = 5'h0c,
    ST_RST  = 5'h0d,
    ST_SND  = 5'h08,
    ST_RDD  = 5'h09,
    ST_DEC  = 5'h0b
  } iaus_state_type;
endpackage : iaus_pkg

// File: rtl/iaus_sequencer.sv
// iaus_sequencer: in-application programming and power-up auto update sequencer.
// assumes requester, nvm port and auto-start come from the clk domain; miso is a pin.
`timescale 1ns/100ps
`default_nettype none
module iaus_sequencer #(
  parameter logic [7:0] DEVICE_ID = 8'h5a, // value is arbitrary
  parameter int         SPI_DIV   = 2
) (
  input  wire logic        clk,                 // 10 MHz system clock
  input  wire logic        rstn,                // async reset, active low
  input  wire logic        inValid,             // communication block byte valid
  input  wire logic  [7:0] inByte,              // communication block byte
  output logic             inReady,             // byte taken when valid and ready
  output logic             respValid,           // one-cycle response pulse
  output logic       [7:0] respStatus,          // response status
  output logic       [7:0] authErrorCode,       // authorization error code
  input  wire logic [15:0] minimumVersionFloor, // lowest allowed design version
  input  wire logic [15:0] currentVersion,      // version now programmed
  input  wire logic        autoEnable,          // auto update enabled
  input  wire logic        autoStart,           // power-up start pulse
  output logic             nvmReq,              // nvm operation request
  output logic             nvmWrite,            // 1 write, 0 read back
  output logic      [15:0] nvmAddr,             // nvm byte address
  output logic       [7:0] nvmWdata,            // nvm write data
  input  wire logic        nvmDone,             // nvm operation finished pulse
  input  wire logic  [7:0] nvmRdata,            // nvm read data at nvmDone
  output logic             busMasterLock,       // exclusive bus lock
  output logic             deviceReset,         // one-cycle whole device reset
  output logic             spiSclk,             // flash clock
  output logic             spiMosi,             // flash data out
  input  wire logic        spiMiso,             // flash data in
  output logic             spiCsN,              // flash select, active low
  output logic             spiOeN,              // port pins enable, low drives
  output logic             extraSlaveSelectA,   // extra select level
  output logic             extraSlaveSelectB,   // extra select level
  output logic             extraSlaveSelectC,   // extra select level
  output logic             extraSlaveSelectD,   // extra select level
  output logic             extraSelectOeN       // extra selects enable, low drives
);
  if (SPI_DIV < 1)
  begin : g_chk
    $error("SPI_DIV must be at least 1");
  end

  typedef struct packed {
    iaus_pkg::iaus_state_type st;
    logic [15:0] cnt;
    logic [15:0] len;
    logic [15:0] ver;
    logic [7:0]  flg;
    logic [7:0]  devId;
    logic [1:0]  mode;
    logic        fromFlash;
    logic        dirPh;
    logic [31:0] addr;
    logic [7:0]  data;
    logic [7:0]  csum;
    logic [7:0]  code;
    logic [7:0]  status;
    logic [15:0] nvmA;
    logic        pend;
    logic        spiGo;
    logic [7:0]  spiTx;
    logic        csN;
    logic        autoAct;
    logic        lock;
    logic        nvmReq;
    logic        nvmWr;
    logic        rdy;
    logic        respV;
    logic        rst;
    logic        oeN;
    logic        xOeN;
  } iaus_seq_type;

  iaus_seq_type s;
  iaus_seq_type n;
  logic         spiDone;
  logic [7:0]   spiRx;

  function automatic logic needByte(input iaus_pkg::iaus_state_type st);
    needByte = st inside {iaus_pkg::ST_IDLE, iaus_pkg::ST_OPT, iaus_pkg::ST_ADR,
                          iaus_pkg::ST_BHD, iaus_pkg::ST_PAY, iaus_pkg::ST_SND,
                          iaus_pkg::ST_RDD};
  endfunction : needByte

  function automatic logic [7:0] sndByte(input logic [15:0] c, input logic [31:0] a);
    unique case (c[1:0])
      2'h0: sndByte = iaus_pkg::FLASH_READ;
      2'h1: sndByte = a[23:16];
      2'h2: sndByte = a[15:8];
      2'h3: sndByte = a[7:0];
    endcase
  endfunction : sndByte

  function automatic logic [7:0] authCheck(input logic [7:0] id, input logic [15:0] v,
                                           input logic [7:0] f, input logic [1:0] m,
                                           input logic [15:0] floor);
    if (id != DEVICE_ID)
      authCheck = iaus_pkg::AUTH_BADID;
    else if (f[iaus_pkg::FLG_OUTDATED])
      authCheck = iaus_pkg::AUTH_OUTDATED;
    else if (v < floor)
      authCheck = iaus_pkg::AUTH_LOWVER;
    else if (m == iaus_pkg::MODE_VERIFY && !f[iaus_pkg::FLG_VERIFY_OK])
      authCheck = iaus_pkg::AUTH_NOVERIFY;
    else
      authCheck = iaus_pkg::AUTH_OK;
  endfunction : authCheck

  always_comb
  begin
    logic       got;
    logic [7:0] b;
    got = 1'b0;
    b = 8'h00;
    n = s;
    n.spiGo = 1'b0;
    n.respV = (s.st == iaus_pkg::ST_RSP);
    n.rst = (s.st == iaus_pkg::ST_RST);
    if (s.fromFlash)
    begin
      got = spiDone;
      b = spiRx;
    end
    else
    begin
      got = inValid && s.rdy;
      b = inByte;
    end
    if (spiDone)
      n.pend = 1'b0;
    if (s.fromFlash && needByte(s.st) && !s.pend)
    begin
      n.spiGo = 1'b1;
      n.pend = 1'b1;
      n.spiTx = (s.st == iaus_pkg::ST_SND) ? sndByte(s.cnt, s.addr) : 8'h00;
    end
    unique case (s.st)
      iaus_pkg::ST_IDLE:
      begin
        if (autoStart && autoEnable)
        begin
          n.fromFlash = 1'b1;
          n.autoAct = 1'b1;
          n.dirPh = 1'b1;
          n.csN = 1'b0;
          n.addr = {8'h00, iaus_pkg::DIR_UPD_OFF};
          n.cnt = '0;
          n.mode = iaus_pkg::MODE_PROG;
          n.code = iaus_pkg::AUTH_OK;
          n.status = iaus_pkg::STAT_OK;
          n.csum = 8'h00;
          n.st = iaus_pkg::ST_SND;
        end
        else if (got && b == iaus_pkg::CMD_PROGRAM)
        begin
          n.code = iaus_pkg::AUTH_OK;
          n.status = iaus_pkg::STAT_OK;
          n.csum = 8'h00;
          n.st = iaus_pkg::ST_OPT;
        end
      end
      iaus_pkg::ST_OPT:
      begin
        if (got)
        begin
          n.mode = b[1:0];
          n.cnt = '0;
          n.st = iaus_pkg::ST_ADR;
          if (b[1:0] > iaus_pkg::MODE_VERIFY)
          begin
            n.code = iaus_pkg::AUTH_CORRUPT;
            n.status = iaus_pkg::STAT_AUTH;
            n.st = iaus_pkg::ST_RSP;
          end
        end
      end
      iaus_pkg::ST_ADR:
      begin
        if (got)
        begin
          n.addr = {b, s.addr[31:8]};
          n.cnt = s.cnt + 16'h1;
          if (s.cnt == iaus_pkg::LAST_ADDR)
          begin
            n.cnt = '0;
            n.st = iaus_pkg::ST_BHD;
          end
        end
      end
      iaus_pkg::ST_SND:
      begin
        if (got)
        begin
          n.cnt = s.cnt + 16'h1;
          if (s.cnt == iaus_pkg::LAST_ADDR)
          begin
            n.cnt = '0;
            n.st = s.dirPh ? iaus_pkg::ST_RDD : iaus_pkg::ST_BHD;
          end
        end
      end
      iaus_pkg::ST_RDD:
      begin
        if (got)
        begin
          if (s.cnt <= iaus_pkg::LAST_ADDR)
            n.addr = {b, s.addr[31:8]};
          else
            n.ver = {b, s.ver[15:8]};
          n.cnt = s.cnt + 16'h1;
          if (s.cnt == iaus_pkg::LAST_DIR)
          begin
            n.csN = 1'b1;
            n.st = iaus_pkg::ST_DEC;
          end
        end
      end
      iaus_pkg::ST_DEC:
      begin
        n.cnt = '0;
        if (s.addr == iaus_pkg::BLANK_ADDR)
        begin
          n.code = iaus_pkg::AUTH_CORRUPT;
          n.status = iaus_pkg::STAT_AUTH;
          n.st = iaus_pkg::ST_RSP;
        end
        else if (s.ver > currentVersion)
        begin
          n.dirPh = 1'b0;
          n.csN = 1'b0;
          n.st = iaus_pkg::ST_SND;
        end
        else
        begin
          n.mode = iaus_pkg::MODE_AUTH;
          n.st = iaus_pkg::ST_RSP;
        end
      end
      iaus_pkg::ST_BHD:
      begin
        if (got)
        begin
          n.csum = s.csum ^ b;
          n.cnt = s.cnt + 16'h1;
          unique case (s.cnt)
            iaus_pkg::HDR_ID:  n.devId = b;
            iaus_pkg::HDR_VLO,
            iaus_pkg::HDR_VHI: n.ver = {b, s.ver[15:8]};
            iaus_pkg::HDR_FLG: n.flg = b;
            iaus_pkg::HDR_LLO: n.len = {b, s.len[15:8]};
            default:
            begin
              n.len = {b, s.len[15:8]};
              n.cnt = '0;
              if (s.code == iaus_pkg::AUTH_OK)
                n.code = authCheck(s.devId, s.ver, s.flg, s.mode, minimumVersionFloor);
              n.st = iaus_pkg::ST_PAY;
            end
          endcase
        end
      end
      iaus_pkg::ST_PAY:
      begin
        if (got && s.cnt == s.len)
        begin
          if (b != s.csum && s.code == iaus_pkg::AUTH_OK)
          begin
            n.code = iaus_pkg::AUTH_CORRUPT;
            n.status = iaus_pkg::STAT_AUTH;
          end
          else if (s.code != iaus_pkg::AUTH_OK)
            n.status = iaus_pkg::STAT_AUTH;
          n.csN = 1'b1;
          n.st = iaus_pkg::ST_RSP;
        end
        else if (got)
        begin
          n.csum = s.csum ^ b;
          n.data = b;
          n.nvmA = s.cnt;
          n.cnt = s.cnt + 16'h1;
          if (s.code == iaus_pkg::AUTH_OK && s.status == iaus_pkg::STAT_OK)
          begin
            if (s.mode == iaus_pkg::MODE_PROG)
              n.st = iaus_pkg::ST_WRT;
            else if (s.mode == iaus_pkg::MODE_VERIFY)
              n.st = iaus_pkg::ST_CHK;
          end
        end
      end
      iaus_pkg::ST_WRT:
      begin
        if (nvmDone)
          n.st = iaus_pkg::ST_GAP;
      end
      iaus_pkg::ST_GAP:
      begin
        n.st = iaus_pkg::ST_CHK;
      end
      iaus_pkg::ST_CHK:
      begin
        if (nvmDone)
        begin
          if (nvmRdata != s.data)
            n.status = iaus_pkg::STAT_PROG;
          n.st = iaus_pkg::ST_PAY;
        end
      end
      iaus_pkg::ST_RSP:
      begin
        n.fromFlash = 1'b0;
        n.autoAct = 1'b0;
        n.csN = 1'b1;
        n.pend = 1'b0;
        if (s.mode == iaus_pkg::MODE_PROG && s.status == iaus_pkg::STAT_OK &&
            s.code == iaus_pkg::AUTH_OK)
          n.st = iaus_pkg::ST_RST;
        else
          n.st = iaus_pkg::ST_IDLE;
      end
      iaus_pkg::ST_RST:
      begin
        n.st = iaus_pkg::ST_IDLE;
      end
      default:
      begin
        n.st = iaus_pkg::ST_IDLE;
      end
    endcase
    n.rdy = !n.fromFlash && needByte(n.st);
    n.lock = (n.st == iaus_pkg::ST_WRT) || (n.st == iaus_pkg::ST_CHK);
    n.nvmReq = n.lock;
    n.nvmWr = (n.st == iaus_pkg::ST_WRT);
    n.oeN = !(n.autoAct && !n.csN);
    n.xOeN = !n.autoAct;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s <= '0;
      s.csN <= 1'b1;
      s.oeN <= 1'b1;
      s.xOeN <= 1'b1;
    end
    else
    begin
      s <= n;
    end
  end

  iaus_spi_byte #(.DIV(SPI_DIV)) u_spi (
    .clk    (clk),
    .rstn   (rstn),
    .start  (s.spiGo),
    .txByte (s.spiTx),
    .done   (spiDone),
    .rxByte (spiRx),
    .sclk   (spiSclk),
    .mosi   (spiMosi),
    .miso   (spiMiso)
  );

  assign inReady           = s.rdy;
  assign respValid         = s.respV;
  assign respStatus        = s.status;
  assign authErrorCode     = s.code;
  assign nvmReq            = s.nvmReq;
  assign nvmWrite          = s.nvmWr;
  assign nvmAddr           = s.nvmA;
  assign nvmWdata          = s.data;
  assign busMasterLock     = s.lock;
  assign deviceReset       = s.rst;
  assign spiCsN            = s.csN;
  assign spiOeN            = s.oeN;
  assign extraSlaveSelectA = s.autoAct;
  assign extraSlaveSelectB = s.autoAct;
  assign extraSlaveSelectC = s.autoAct;
  assign extraSlaveSelectD = s.autoAct;
  assign extraSelectOeN    = s.xOeN;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_wrDone;
    s.st == iaus_pkg::ST_WRT && nvmDone;
  endsequence
  sequence s_gapThenRead;
    !busMasterLock ##1 (busMasterLock && !nvmWrite);
  endsequence

  property p_codeZero;
    respValid |-> ((authErrorCode == iaus_pkg::AUTH_OK) == (respStatus != iaus_pkg::STAT_AUTH));
  endproperty
  a_codeZero: assert property (p_codeZero) else $error("code and status disagree");
  property p_lowVer;
    respValid && authErrorCode == iaus_pkg::AUTH_LOWVER |-> s.ver < minimumVersionFloor;
  endproperty
  a_lowVer: assert property (p_lowVer) else $error("low version code without cause");
  property p_codes;
    respValid |-> (authErrorCode != iaus_pkg::AUTH_BADID || s.devId != DEVICE_ID) &&
                  (authErrorCode != iaus_pkg::AUTH_OUTDATED || s.flg[iaus_pkg::FLG_OUTDATED]) &&
                  (authErrorCode != iaus_pkg::AUTH_NOVERIFY || s.mode == iaus_pkg::MODE_VERIFY);
  endproperty
  a_codes: assert property (p_codes) else $error("error code without cause");
  property p_readyInPay;
    s.st == iaus_pkg::ST_PAY && !s.fromFlash |-> inReady && !busMasterLock;
  endproperty
  a_readyInPay: assert property (p_readyInPay) else $error("stream stalled in payload");
  property p_lockGap;
    s_wrDone |=> s_gapThenRead;
  endproperty
  a_lockGap: assert property (p_lockGap) else $error("lock held across nvm ops");
  property p_resetAfterProg;
    respValid && s.mode == iaus_pkg::MODE_PROG && respStatus == iaus_pkg::STAT_OK &&
      authErrorCode == iaus_pkg::AUTH_OK |=> deviceReset ##1 !deviceReset;
  endproperty
  a_resetAfterProg: assert property (p_resetAfterProg) else $error("missing reset");
  property p_noResetOnFail;
    respValid && authErrorCode != iaus_pkg::AUTH_OK |=> !deviceReset;
  endproperty
  a_noResetOnFail: assert property (p_noResetOnFail) else $error("reset after failure");
  property p_blank;
    s.st == iaus_pkg::ST_DEC && s.addr == iaus_pkg::BLANK_ADDR |=>
      authErrorCode == iaus_pkg::AUTH_CORRUPT ##1 respValid ##1 !deviceReset;
  endproperty
  a_blank: assert property (p_blank) else $error("blank flash not rejected");
  property p_oldVersion;
    s.st == iaus_pkg::ST_DEC && s.addr != iaus_pkg::BLANK_ADDR && s.ver <= currentVersion
      |=> s.st == iaus_pkg::ST_RSP ##1 !nvmReq ##1 !deviceReset;
  endproperty
  a_oldVersion: assert property (p_oldVersion) else $error("old image programmed");
  property p_extraSel;
    s.st == iaus_pkg::ST_IDLE && autoStart && autoEnable |=>
      extraSlaveSelectA && extraSlaveSelectD && !extraSelectOeN && !spiOeN;
  endproperty
  a_extraSel: assert property (p_extraSel) else $error("extra selects not driven");
  property p_verifyInProg;
    s_wrDone |=> ##1 (s.st == iaus_pkg::ST_CHK && nvmReq && !nvmWrite);
  endproperty
  a_verifyInProg: assert property (p_verifyInProg) else $error("program not verified");
endmodule : iaus_sequencer
`default_nettype wire

// File: rtl/iaus_spi_byte.sv
// iaus_spi_byte: one-byte spi mode 0 shift engine for the flash port.
// assumes the caller drives chip select and starts only while idle.
`timescale 1ns/100ps
`default_nettype none
module iaus_spi_byte #(
  parameter int DIV = 2
) (
  input  wire logic       clk,     // system clock
  input  wire logic       rstn,    // async reset, active low
  input  wire logic       start,   // start a byte while idle
  input  wire logic [7:0] txByte,  // byte to send
  output logic            done,    // one-cycle pulse, rxByte valid
  output logic      [7:0] rxByte,  // byte received
  output logic            sclk,    // spi clock
  output logic            mosi,    // spi data out
  input  wire logic       miso     // spi data in, from pin
);
  localparam int DW = $clog2(DIV) + 1;
  if (DIV < 1)
  begin : g_chk
    $error("DIV must be at least 1");
  end

  typedef struct packed {
    logic [DW-1:0] div;
    logic [2:0]    bits;
    logic          busy;
    logic          sclk;
    logic [7:0]    tx;
    logic [7:0]    rx;
    logic          done;
    logic          m0;
    logic          m1;
    logic          smp0;
    logic          smp1;
    logic          lst0;
    logic          lst1;
    logic          full;
  } iaus_spi_type;

  iaus_spi_type s;
  iaus_spi_type n;

  always_comb
  begin
    n = s;
    n.done = 1'b0;
    n.m0 = miso;
    n.m1 = s.m0;
    n.smp0 = 1'b0;
    n.lst0 = 1'b0;
    n.smp1 = s.smp0;
    n.lst1 = s.lst0;
    // miso reaches m1 two cycles late: take the bit that stood at the rising edge
    if (s.smp1)
    begin
      n.rx = {s.rx[6:0], s.m1};
      if (s.lst1)
      begin
        n.full = 1'b1;
      end
    end
    if (start && !s.busy)
    begin
      n.busy = 1'b1;
      n.tx = txByte;
      n.bits = 3'h0;
      n.div = '0;
      n.sclk = 1'b0;
    end
    else if (s.busy)
    begin
      n.div = s.div + DW'(1);
      if (s.div == DW'(DIV - 1))
      begin
        n.div = '0;
        n.sclk = !s.sclk;
        if (!s.sclk)
        begin
          n.smp0 = 1'b1;
          n.lst0 = (s.bits == 3'h7);
        end
        else
        begin
          n.tx = {s.tx[6:0], 1'b0};
          n.bits = s.bits + 3'h1;
          if (s.bits == 3'h7)
          begin
            n.busy = 1'b0;
          end
        end
      end
    end
    // done waits for both the last sample and the last falling edge
    if (n.full && !n.busy)
    begin
      n.full = 1'b0;
      n.done = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s <= '0;
    end
    else
    begin
      s <= n;
    end
  end

  assign done   = s.done;
  assign rxByte = s.rx;
  assign sclk   = s.sclk;
  assign mosi   = s.tx[7];
endmodule : iaus_spi_byte
`default_nettype wire

// File: tb/iaus_nvm_model.sv
// iaus_nvm_model: embedded nvm partner, one cycle per operation.
// assumes requests hold until the done pulse; keeps 16 bytes.
`timescale 1ns/100ps
`default_nettype none
module iaus_nvm_model (
  input  wire logic        clk,      // system clock
  input  wire logic        rstn,     // async reset, active low
  input  wire logic        nvmReq,   // operation request level
  input  wire logic        nvmWrite, // 1 write, 0 read back
  input  wire logic [15:0] nvmAddr,  // byte address
  input  wire logic  [7:0] nvmWdata, // write data
  output logic             nvmDone,  // one-cycle done pulse
  output logic       [7:0] nvmRdata  // read data at done
);
  logic [7:0] mem [0:15]; // only bench requests reach it, no code fetch
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      nvmDone  <= 1'b0;
      nvmRdata <= 8'h00;
    end
    else
    begin
      nvmDone  <= nvmReq && !nvmDone;
      // off a read, the data lines show no stale byte
      nvmRdata <= ~nvmRdata;
      if (nvmReq && !nvmDone && nvmWrite)
        mem[nvmAddr[3:0]] <= nvmWdata;
      if (nvmReq && !nvmDone && !nvmWrite)
        nvmRdata <= mem[nvmAddr[3:0]];
    end
  end
endmodule : iaus_nvm_model
`default_nettype wire

// File: tb/tb_top.sv
// tb_top: self-checking bench for the programming sequencer.
// assumes the nvm model as partner and a flash that drives flashLevel while selected, blank (all ones) or all zeros.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk, rstn, inValid, inReady, respValid, autoEnable, autoStart;
  logic nvmReq, nvmWrite, nvmDone, busMasterLock, deviceReset, lockPrev;
  logic spiSclk, spiMosi, spiMiso, spiCsN, spiOeN, selA, selB, selC, selD, selOeN;
  logic [7:0]  inByte, respStatus, authErrorCode, nvmWdata, nvmRdata;
  logic [15:0] nvmAddr;
  int          numErrors, checksDone, cycles, resets, locks, mosiCnt;
  logic        flashLevel;
  logic [31:0] mosiWord;

  // deselected flash releases miso to its pull-up; the bench owns the pins
  assign spiMiso = spiCsN ? 1'b1 : flashLevel;

  iaus_sequencer #(.SPI_DIV(1)) u_iaus_sequencer (.clk(clk), .rstn(rstn),
    .inValid(inValid), .inByte(inByte), .inReady(inReady), .respValid(respValid),
    .respStatus(respStatus), .authErrorCode(authErrorCode),
    .minimumVersionFloor(16'h0010), .currentVersion(16'h0010),
    .autoEnable(autoEnable), .autoStart(autoStart), .nvmReq(nvmReq),
    .nvmWrite(nvmWrite), .nvmAddr(nvmAddr), .nvmWdata(nvmWdata), .nvmDone(nvmDone),
    .nvmRdata(nvmRdata), .busMasterLock(busMasterLock), .deviceReset(deviceReset),
    .spiSclk(spiSclk), .spiMosi(spiMosi), .spiMiso(spiMiso), .spiCsN(spiCsN),
    .spiOeN(spiOeN), .extraSlaveSelectA(selA), .extraSlaveSelectB(selB),
    .extraSlaveSelectC(selC), .extraSlaveSelectD(selD), .extraSelectOeN(selOeN));
  iaus_nvm_model u_iaus_nvm_model (.clk(clk), .rstn(rstn), .nvmReq(nvmReq),
    .nvmWrite(nvmWrite), .nvmAddr(nvmAddr), .nvmWdata(nvmWdata),
    .nvmDone(nvmDone), .nvmRdata(nvmRdata));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // counts lock grants and reset pulses, cuts a hang short
  always @(posedge clk)
  begin
    cycles++;
    lockPrev <= busMasterLock;
    if (busMasterLock === 1'b1 && lockPrev !== 1'b1)
      locks++;
    if (deviceReset === 1'b1)
      resets++; // user logic would add its second reset after this
    if (cycles == 20000)
    begin
      numErrors++;
      final_report;
    end
  end

  // gathers the first four bytes sent to the flash in each frame
  always @(posedge spiSclk or negedge spiCsN)
  begin
    if (spiSclk === 1'b0)
      mosiCnt = 0;
    else if (spiCsN === 1'b0 && mosiCnt < 32)
    begin
      mosiWord = {mosiWord[30:0], spiMosi};
      mosiCnt++;
    end
  end

  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
  begin
    checksDone++;
    if (got !== exp)
    begin
      numErrors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  end
  endtask : chk

  task send(input logic [7:0] b);
  begin
    @(negedge clk);
    inValid = 1'b1;
    inByte = b;
    @(posedge clk);
    while (inReady !== 1'b1) @(posedge clk);
  end
  endtask : send

  task wait_resp;
  begin
    do @(posedge clk); while (respValid !== 1'b1);
    repeat (3) @(negedge clk);
  end
  endtask : wait_resp

  // full request with a two-byte payload a5 3c and a good checksum
  task req(input logic [1:0] mode, input logic [7:0] id, flg, input logic [15:0] ver,
           input logic [7:0] expStat, expCode, input int expRst, expLocks);
    logic [7:0] sum;
    int         r0, l0;
  begin
    r0 = resets;
    l0 = locks;
    sum = id ^ ver[7:0] ^ ver[15:8] ^ flg ^ 8'h02 ^ 8'ha5 ^ 8'h3c;
    send(iaus_pkg::CMD_PROGRAM);
    send({6'h00, mode});
    for (int i = 0; i < 4; i++) send(8'h00);
    send(id);
    send(ver[7:0]);
    send(ver[15:8]);
    send(flg);
    send(8'h02);
    send(8'h00);
    send(8'ha5);
    send(8'h3c);
    send(sum);
    @(negedge clk);
    inValid = 1'b0;
    wait_resp;
    chk("status", expStat, respStatus);
    chk("code", expCode, authErrorCode);
    chk("device resets", 8'(expRst), 8'(resets - r0));
    chk("lock grants", 8'(expLocks), 8'(locks - l0));
  end
  endtask : req

  task t_prog;
  begin
    req(iaus_pkg::MODE_PROG, 8'h5a, 8'h01, 16'h0020, 8'h00, 8'h00, 1, 4);
    $display("test program done");
  end
  endtask : t_prog

  task t_verify;
  begin
    req(iaus_pkg::MODE_VERIFY, 8'h5a, 8'h01, 16'h0020, 8'h00, 8'h00, 0, 2);
    $display("test verify done");
  end
  endtask : t_verify

  task t_errors;
  begin
    req(iaus_pkg::MODE_PROG, 8'h33, 8'h01, 16'h0020, 8'h01, 8'h0a, 0, 0);
    req(iaus_pkg::MODE_PROG, 8'h5a, 8'h03, 16'h0020, 8'h01, 8'h0b, 0, 0);
    req(iaus_pkg::MODE_PROG, 8'h5a, 8'h01, 16'h0008, 8'h01, 8'h05, 0, 0);
    req(iaus_pkg::MODE_VERIFY, 8'h5a, 8'h00, 16'h0020, 8'h01, 8'h0c, 0, 0);
    $display("test error codes done");
  end
  endtask : t_errors

  task t_auto;
    int r0;
  begin
    r0 = resets;
    @(negedge clk);
    autoStart = 1'b1;
    @(negedge clk);
    autoStart = 1'b0;
    @(posedge clk);
    while (spiCsN !== 1'b0) @(posedge clk);
    @(negedge clk);
    chk("extra selects", 8'h0f, {4'h0, selA, selB, selC, selD});
    chk("extra select enable", 8'h00, {7'h00, selOeN});
    chk("port enable", 8'h00, {7'h00, spiOeN});
    wait_resp;
    chk("auto status", iaus_pkg::STAT_AUTH, respStatus);
    chk("auto code", iaus_pkg::AUTH_CORRUPT, authErrorCode);
    chk("auto resets", 8'h00, 8'(resets - r0));
    chk("selects after", 8'h00, {4'h0, selA, selB, selC, selD});
    chk("flash command", iaus_pkg::FLASH_READ, mosiWord[31:24]);
    chk("directory offset", iaus_pkg::DIR_UPD_OFF[7:0], mosiWord[7:0]);
    $display("test blank flash done");
  end
  endtask : t_auto

  // directory of zeros: image at address 0 with version 0, not newer
  task t_auto_old;
    int r0, l0;
  begin
    r0 = resets;
    l0 = locks;
    @(negedge clk);
    flashLevel = 1'b0; // one image and its directory in place
    autoStart = 1'b1;
    @(negedge clk);
    autoStart = 1'b0;
    wait_resp;
    chk("old status", iaus_pkg::STAT_OK, respStatus);
    chk("old code", iaus_pkg::AUTH_OK, authErrorCode);
    chk("old resets", 8'h00, 8'(resets - r0));
    chk("old lock grants", 8'h00, 8'(locks - l0));
    chk("old flash command", iaus_pkg::FLASH_READ, mosiWord[31:24]);
    $display("test older image done");
  end
  endtask : t_auto_old

  task final_report;
  begin
    $display("checks %0d mismatches %0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask : final_report

  initial
  begin
    rstn = 1'b0;
    inValid = 1'b0;
    inByte = 8'h00;
    autoEnable = 1'b1;
    autoStart = 1'b0;
    flashLevel = 1'b1;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    t_prog;
    t_verify;
    t_errors;
    t_auto;
    t_auto_old;
    final_report;
  end
endmodule : tb_top
`default_nettype wire
